// *** rtl/fpo_defines.svh ***
// constants for the centered pwm output stage and status flag word
`ifndef FPO_DEFINES_SVH
`define FPO_DEFINES_SVH

// ==========================================
// register byte offsets
`define FPO_ADDR_CTRL 12'h000
`define FPO_ADDR_PERIOD 12'h004
`define FPO_ADDR_DT_HS 12'h008
`define FPO_ADDR_DT_LS 12'h00c
`define FPO_ADDR_DUTY_UV 12'h010
`define FPO_ADDR_DUTY_WY 12'h014
`define FPO_ADDR_INT_SEL 12'h018
`define FPO_ADDR_INT_DATA 12'h01c
`define FPO_ADDR_FLAGS 12'h020
`define FPO_ADDR_MASK 12'h024

// ==========================================
// control register fields
`define FPO_CTRL_MODE_LSB 0
`define FPO_CTRL_SVM_BIT 4
`define FPO_CTRL_MOTOR_LSB 8

// ==========================================
// reset values and codes
`define FPO_PERIOD_RST 16'h0f9f
`define FPO_DT_RST 8'h14
`define FPO_FLAGS_RST 32'h0000_0000
`define FPO_MASK_RST 32'h0000_0000
`define FPO_FLAGS_RSVD 32'h8088_2222
`define FPO_INT_SEL_UV 8'h11
`define FPO_INT_SEL_WY 8'h12
`define FPO_U16_OFFSET 16'h8000
`define FPO_SVM_GAIN 17'h093cd
`define FPO_DUTY_MIN 16'h0000
`define FPO_DUTY_MAX 16'hffff

// ==========================================
// timing
`define FPO_CLK_NS 10
`define FPO_DT_UNIT_NS 10
`define FPO_DT_UNIT_CYC ((`FPO_DT_UNIT_NS + `FPO_CLK_NS - 1) / `FPO_CLK_NS)

`endif

// *** rtl/fpo_pkg.sv ***
// types for the centered pwm output stage
package fpo_pkg;

    typedef enum logic [2:0] {
        FPO_MODE_OFF = 3'b000,
        FPO_MODE_FREEWHEEL = 3'b001,
        FPO_MODE_BRAKE_LS = 3'b010,
        FPO_MODE_BRAKE_HS = 3'b011,
        FPO_MODE_CENTERED = 3'b111
    } fpo_mode_t;

    typedef enum logic [1:0] {
        FPO_MOTOR_DC = 2'b01,
        FPO_MOTOR_STEPPER = 2'b10,
        FPO_MOTOR_THREE = 2'b11
    } fpo_motor_t;

    // limiter and detector levels from the controller core, same clock
    typedef struct packed {
        logic [2:0] pid_pos;
        logic [2:0] pid_vel;
        logic [2:0] pid_flux;
        logic [2:0] pid_torque;
        logic [2:0] cir_lim;
        logic adc_cur_clip;
        logic adc_enc_clip;
        logic encoder1_index_flag;
        logic encoder2_index_flag;
        logic aenc_index;
    } fpo_flag_src_t;

    typedef struct packed {
        logic [3:0] hs;
        logic [3:0] ls;
    } fpo_gates_t;

endpackage : fpo_pkg

// *** rtl/fpo_top.sv ***
// centered pwm output stage with dead time, svm and status flag word
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "fpo_defines.svh"

module fpo_top #(
    parameter int CNT_W = 16,
    parameter int DT_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fpo_pkg::fpo_flag_src_t flag_src,
    input wire logic [2:0] ref_sw_pins,
    output fpo_pkg::fpo_gates_t gates,
    output logic status_out
);
    import fpo_pkg::*;

    // ==========================================
    // registers
    logic [2:0] mode_ff;
    logic svm_en_ff;
    logic [1:0] motor_ff;
    logic [CNT_W-1:0] period_max_count_ff;
    logic [DT_W-1:0] dead_time_hs_ff;
    logic [DT_W-1:0] dead_time_ls_ff;
    logic [15:0] duty_ff [4];
    logic [7:0] int_sel_ff;
    logic [31:0] flags_ff;
    logic [31:0] mask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic status_ff;
    fpo_gates_t gates_ff;

    logic acc;
    logic wr_en;
    logic hit;
    logic [31:0] rd_mux;
    logic [31:0] int_data;
    logic [31:0] nxt_flags;
    logic [31:0] flag_ev;

    // ==========================================
    // apb slave: one wait state, pready from a flop
    assign acc = psel && penable && clk_en;
    assign wr_en = acc && pready_ff && pwrite;

    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `FPO_ADDR_CTRL: rd_mux = {22'h00_0000, motor_ff, 3'h0, svm_en_ff, 1'b0, mode_ff};
            `FPO_ADDR_PERIOD: rd_mux = 32'(period_max_count_ff);
            `FPO_ADDR_DT_HS: rd_mux = 32'(dead_time_hs_ff);
            `FPO_ADDR_DT_LS: rd_mux = 32'(dead_time_ls_ff);
            `FPO_ADDR_DUTY_UV: rd_mux = {duty_ff[1], duty_ff[0]};
            `FPO_ADDR_DUTY_WY: rd_mux = {duty_ff[3], duty_ff[2]};
            `FPO_ADDR_INT_SEL: rd_mux = {24'h00_0000, int_sel_ff};
            `FPO_ADDR_INT_DATA: rd_mux = int_data;
            `FPO_ADDR_FLAGS: rd_mux = flags_ff;
            `FPO_ADDR_MASK: rd_mux = mask_ff;
            default: hit = 1'b0;
        endcase
    end

    // signed duty readback through the interim port
    always_comb begin
        case (int_sel_ff)
            `FPO_INT_SEL_UV: int_data = {duty_ff[1], duty_ff[0]};
            `FPO_INT_SEL_WY: int_data = {duty_ff[3], duty_ff[2]};
            default: int_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            pready_ff <= acc && !pready_ff;
            pslverr_ff <= acc && !pready_ff && !hit;
            if (acc && !pready_ff) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= FPO_MODE_OFF;
            svm_en_ff <= 1'b0;
            motor_ff <= FPO_MOTOR_THREE;
            period_max_count_ff <= CNT_W'(`FPO_PERIOD_RST);
            dead_time_hs_ff <= DT_W'(`FPO_DT_RST);
            dead_time_ls_ff <= DT_W'(`FPO_DT_RST);
            int_sel_ff <= 8'h00;
            mask_ff <= `FPO_MASK_RST;
            for (int i = 0; i < 4; i++) begin
                duty_ff[i] <= 16'h0000;
            end
        end else if (wr_en) begin
            case (paddr)
                `FPO_ADDR_CTRL: begin
                    mode_ff <= pwdata[`FPO_CTRL_MODE_LSB +: 3];
                    svm_en_ff <= pwdata[`FPO_CTRL_SVM_BIT];
                    motor_ff <= pwdata[`FPO_CTRL_MOTOR_LSB +: 2];
                end
                `FPO_ADDR_PERIOD: period_max_count_ff <= pwdata[CNT_W-1:0];
                `FPO_ADDR_DT_HS: dead_time_hs_ff <= pwdata[DT_W-1:0];
                `FPO_ADDR_DT_LS: dead_time_ls_ff <= pwdata[DT_W-1:0];
                `FPO_ADDR_DUTY_UV: begin
                    duty_ff[0] <= pwdata[15:0];
                    duty_ff[1] <= pwdata[31:16];
                end
                `FPO_ADDR_DUTY_WY: begin
                    duty_ff[2] <= pwdata[15:0];
                    duty_ff[3] <= pwdata[31:16];
                end
                `FPO_ADDR_INT_SEL: int_sel_ff <= pwdata[7:0];
                `FPO_ADDR_MASK: mask_ff <= pwdata;
                default: ;
            endcase
        end
    end

    // ==========================================
    // symmetric up-down counter, one step per 10 ns
    logic [CNT_W-1:0] cnt_ff;
    logic cnt_down_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
            cnt_down_ff <= 1'b0;
        end else if (clk_en) begin
            if (!cnt_down_ff) begin
                // zero period parks the counter instead of wrapping
                if (period_max_count_ff == '0) begin
                    cnt_ff <= '0;
                end else if (cnt_ff >= period_max_count_ff) begin
                    cnt_down_ff <= 1'b1;
                    cnt_ff <= period_max_count_ff - CNT_W'(1);
                end else begin
                    cnt_ff <= cnt_ff + CNT_W'(1);
                end
            end else if (cnt_ff == '0) begin
                cnt_down_ff <= 1'b0;
                cnt_ff <= CNT_W'(1);
            end else begin
                cnt_ff <= cnt_ff - CNT_W'(1);
            end
        end
    end

    // ==========================================
    // duty conversion: signed to unsigned compare values
    logic signed [16:0] ph_max;
    logic signed [16:0] ph_min;
    logic signed [16:0] ph_mid;
    logic [15:0] cmp_hs [4];
    logic [15:0] cmp_ls [4];
    logic three_phase;

    assign three_phase = (motor_ff == FPO_MOTOR_THREE);

    always_comb begin
        ph_max = 17'(signed'(duty_ff[0]));
        ph_min = 17'(signed'(duty_ff[0]));
        for (int i = 1; i < 3; i++) begin
            if (17'(signed'(duty_ff[i])) > ph_max) begin
                ph_max = 17'(signed'(duty_ff[i]));
            end
            if (17'(signed'(duty_ff[i])) < ph_min) begin
                ph_min = 17'(signed'(duty_ff[i]));
            end
        end
        ph_mid = (ph_max + ph_min) >>> 1;
    end

    // saturate to s16 then offset by 0x8000
    function automatic logic [15:0] fpo_to_u16(input logic signed [35:0] v);
        logic [15:0] s;
        s = 16'h0000;
        if (v > 36'sd32767) begin
            s = 16'h7fff;
        end else if (v < -36'sd32768) begin
            s = 16'h8000;
        end else begin
            s = v[15:0];
        end
        s = 16'(s + `FPO_U16_OFFSET);
        return s;
    endfunction : fpo_to_u16

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (svm_en_ff && three_phase && i < 3) begin
                cmp_hs[i] = fpo_to_u16(((36'(signed'(duty_ff[i])) - 36'(ph_mid))
                    * 36'(signed'({1'b0, `FPO_SVM_GAIN}))) >>> 15);
            end else begin
                cmp_hs[i] = fpo_to_u16(36'(signed'(duty_ff[i])));
            end
            if (three_phase) begin
                cmp_ls[i] = cmp_hs[i];
            end else begin
                cmp_ls[i] = fpo_to_u16(-36'(signed'(duty_ff[i])));
            end
        end
    end

    // ==========================================
    // compare: 16-bit value scaled onto the counter range
    logic [3:0] raw_hs;
    logic [3:0] raw_ls;
    logic [3:0] used;
    logic [CNT_W:0] thr_hs [4];
    logic [CNT_W:0] thr_ls [4];

    always_comb begin
        case (motor_ff)
            FPO_MOTOR_DC: used = 4'b0011;
            FPO_MOTOR_STEPPER: used = 4'b1111;
            default: used = 4'b0111;
        endcase
        for (int i = 0; i < 4; i++) begin
            thr_hs[i] = (CNT_W+1)'((33'(cmp_hs[i]) * (33'(period_max_count_ff) + 33'd1)) >> 16);
            thr_ls[i] = (CNT_W+1)'((33'(cmp_ls[i]) * (33'(period_max_count_ff) + 33'd1)) >> 16);
            raw_hs[i] = used[i] && ({1'b0, cnt_ff} < thr_hs[i]);
            if (three_phase) begin
                raw_ls[i] = used[i] && !({1'b0, cnt_ff} < thr_ls[i]);
            end else begin
                // low side on-time sits at the count peak, clear of the high side
                raw_ls[i] = used[i]
                    && ({1'b0, cnt_ff} + thr_ls[i] > {1'b0, period_max_count_ff});
            end
        end
    end

    // ==========================================
    // dead time on each gate's rising edge, then output modes
    logic [DT_W-1:0] dt_hs_cnt_ff [4];
    logic [DT_W-1:0] dt_ls_cnt_ff [4];

    generate
        for (genvar g = 0; g < 4; g++) begin : g_gate
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dt_hs_cnt_ff[g] <= '0;
                    dt_ls_cnt_ff[g] <= '0;
                end else if (clk_en) begin
                    if (!raw_hs[g]) begin
                        dt_hs_cnt_ff[g] <= '0;
                    end else if (dt_hs_cnt_ff[g] < dead_time_hs_ff) begin
                        dt_hs_cnt_ff[g] <= dt_hs_cnt_ff[g] + DT_W'(`FPO_DT_UNIT_CYC);
                    end
                    if (!raw_ls[g]) begin
                        dt_ls_cnt_ff[g] <= '0;
                    end else if (dt_ls_cnt_ff[g] < dead_time_ls_ff) begin
                        dt_ls_cnt_ff[g] <= dt_ls_cnt_ff[g] + DT_W'(`FPO_DT_UNIT_CYC);
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gates_ff <= '0;
        end else if (clk_en) begin
            case (fpo_mode_t'(mode_ff))
                FPO_MODE_CENTERED: begin
                    for (int i = 0; i < 4; i++) begin
                        // zero setting passes the gate at once
                        gates_ff.hs[i] <= raw_hs[i] && (dt_hs_cnt_ff[i] >= dead_time_hs_ff);
                        gates_ff.ls[i] <= raw_ls[i] && (dt_ls_cnt_ff[i] >= dead_time_ls_ff);
                    end
                end
                FPO_MODE_BRAKE_LS: begin
                    gates_ff.hs <= 4'h0;
                    gates_ff.ls <= used;
                end
                FPO_MODE_BRAKE_HS: begin
                    gates_ff.hs <= used;
                    gates_ff.ls <= 4'h0;
                end
                default: gates_ff <= '0;
            endcase
        end
    end

    // ==========================================
    // status flags
    logic [2:0] ref_sync1_ff;
    logic [2:0] ref_sync2_ff;
    logic [2:0] ref_prev_ff;
    logic pwm_min_ev;
    logic pwm_max_ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_sync1_ff <= 3'h0;
            ref_sync2_ff <= 3'h0;
            ref_prev_ff <= 3'h0;
        end else if (clk_en) begin
            ref_sync1_ff <= ref_sw_pins;
            ref_sync2_ff <= ref_sync1_ff;
            ref_prev_ff <= ref_sync2_ff;
        end
    end

    always_comb begin
        pwm_min_ev = 1'b0;
        pwm_max_ev = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (used[i] && mode_ff == FPO_MODE_CENTERED) begin
                pwm_min_ev = pwm_min_ev || (cmp_hs[i] == `FPO_DUTY_MIN);
                pwm_max_ev = pwm_max_ev || (cmp_hs[i] == `FPO_DUTY_MAX);
            end
        end
    end

    assign flag_ev = {
        1'b0, flag_src.aenc_index, flag_src.encoder2_index_flag,
        flag_src.encoder1_index_flag,
        flag_src.adc_enc_clip, flag_src.adc_cur_clip,
        pwm_max_ev, pwm_min_ev, 1'b0,
        ref_sync2_ff & ~ref_prev_ff,
        1'b0, flag_src.cir_lim,
        flag_src.pid_torque[2:1], 1'b0, flag_src.pid_torque[0],
        flag_src.pid_flux[2:1], 1'b0, flag_src.pid_flux[0],
        flag_src.pid_vel[2:1], 1'b0, flag_src.pid_vel[0],
        flag_src.pid_pos[2:1], 1'b0, flag_src.pid_pos[0]};

    // word write replaces all non-reserved bits, reserved bits stay zero; a new event still wins
    always_comb begin
        nxt_flags = flags_ff;
        if (wr_en && paddr == `FPO_ADDR_FLAGS) begin
            nxt_flags = pwdata;
        end
        nxt_flags = (nxt_flags | flag_ev) & ~`FPO_FLAGS_RSVD;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= `FPO_FLAGS_RST;
            status_ff <= 1'b0;
        end else if (clk_en) begin
            flags_ff <= nxt_flags;
            status_ff <= |(flags_ff & mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign gates = gates_ff;
    assign status_out = status_ff;

endmodule : fpo_top

// *** tb/fpo_gate_drv_model.sv ***
// behavioural half-bridge gate driver model fed by the gate signals
`timescale 1ns/100ps
module fpo_gate_drv_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire fpo_pkg::fpo_gates_t gates,
    output logic [3:0] bridge_ff,
    output logic shoot_ff
);
    import fpo_pkg::*;
    // ==========================================
    // bridge node, floats to inverse of last level when both switches off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_ff <= 4'h0;
        end else begin
            bridge_ff <= gates.hs | (~gates.ls & ~bridge_ff);
        end
    end
    // ==========================================
    // both switches of one bridge on shorts the supply
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shoot_ff <= 1'b0;
        end else if (|(gates.hs & gates.ls)) begin
            shoot_ff <= 1'b1;
        end
    end
endmodule : fpo_gate_drv_model

// *** tb/fpo_top_sva.sv ***
// concurrent checks on the ports of the pwm output stage
`timescale 1ns/100ps
`include "fpo_defines.svh"
module fpo_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire fpo_pkg::fpo_flag_src_t flag_src,
    input wire logic [2:0] ref_sw_pins,
    input wire fpo_pkg::fpo_gates_t gates,
    input wire logic status_out
);
    import fpo_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_seen_ff;
    logic [31:0] seen_ff, seen_d1_ff, seen_d2_ff, src_map;
    logic rd_flags, wr_flags;
    assign rd_flags = pready && !pwrite && paddr == `FPO_ADDR_FLAGS;
    assign wr_flags = pready && pwrite && paddr == `FPO_ADDR_FLAGS;
    // ==========================================
    // flag bits that events must have set
    assign src_map = {1'b0, flag_src.aenc_index, flag_src.encoder2_index_flag,
        flag_src.encoder1_index_flag, flag_src.adc_enc_clip, flag_src.adc_cur_clip, 7'h0,
        flag_src.cir_lim, flag_src.pid_torque[2:1], 1'b0, flag_src.pid_torque[0],
        flag_src.pid_flux[2:1], 1'b0, flag_src.pid_flux[0],
        flag_src.pid_vel[2:1], 1'b0, flag_src.pid_vel[0],
        flag_src.pid_pos[2:1], 1'b0, flag_src.pid_pos[0]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_seen_ff <= 1'b0;
        end else if (pready && pwrite) begin
            wr_seen_ff <= 1'b1;
        end
    end
    // two stages of lag keep the check conservative against read latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_ff <= 32'h0;
            seen_d1_ff <= 32'h0;
            seen_d2_ff <= 32'h0;
        end else if (wr_flags) begin
            seen_ff <= src_map;
            seen_d1_ff <= 32'h0;
            seen_d2_ff <= 32'h0;
        end else if (clk_en) begin
            seen_ff <= seen_ff | src_map;
            seen_d1_ff <= seen_ff;
            seen_d2_ff <= seen_d1_ff;
        end
    end
    // ==========================================
    // bus, flag and gate checks
    ack_wait_a: assert property (psel && !penable && clk_en ##1 clk_en |=> pready)
        else $error("pready late after access phase");
    ack_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    err_with_ack_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    unmapped_zero_a: assert property (pready && paddr > `FPO_ADDR_MASK |-> pslverr && !prdata)
        else $error("unmapped access not refused");
    rsvd_zero_a: assert property (rd_flags |-> !(prdata & `FPO_FLAGS_RSVD))
        else $error("reserved flag bit read as one");
    flag_sticky_a: assert property (rd_flags |-> (prdata & seen_d2_ff) == seen_d2_ff)
        else $error("flag lost before overwrite");
    off_until_cfg_a: assert property (!wr_seen_ff |-> gates == 8'h0)
        else $error("gates active before any configuration");
    no_overlap_a: assert property (!(gates.hs & gates.ls))
        else $error("high and low side on together");
    status_idle_a: assert property (!wr_seen_ff |-> !status_out)
        else $error("status output with reset mask");
endmodule : fpo_top_sva
bind fpo_top fpo_top_sva u_sva (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flag_src(flag_src), .ref_sw_pins(ref_sw_pins),
    .gates(gates), .status_out(status_out));

// *** tb/fpo_top_tb.sv ***
// self-checking bench for the pwm output stage and status flags
`timescale 1ns/100ps
`include "fpo_defines.svh"
module fpo_top_tb;
    import fpo_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, status_out, shoot_ff, er;
    fpo_flag_src_t flag_src = '0;
    logic [2:0] ref_sw_pins = 3'h0;
    fpo_gates_t gates;
    logic [3:0] bridge_ff;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    localparam int SRC_BIT [20] = '{30, 29, 28, 27, 26, 16, 17, 18, 12, 14, 15, 8, 10, 11,
        4, 6, 7, 0, 2, 3};
    always #5 pclk = ~pclk;
    fpo_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flag_src(flag_src), .ref_sw_pins(ref_sw_pins),
        .gates(gates), .status_out(status_out));
    fpo_gate_drv_model drv_u (.pclk(pclk), .presetn(presetn), .gates(gates),
        .bridge_ff(bridge_ff), .shoot_ff(shoot_ff));
    // ==========================================
    // common tasks
    task final_report;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task rd_chk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rd_chk
    function automatic logic lvl(input logic to_ls);
        return to_ls ? gates.ls[0] : gates.hs[0];
    endfunction : lvl
    task wait_lvl(input logic to_ls, input logic v);
        int n;
        n = 0;
        @(negedge pclk);
        while (lvl(to_ls) !== v && n < 1000) begin
            @(negedge pclk);
            n++;
        end
    endtask : wait_lvl
    // counts cycles with both sides off before the given side turns on
    task gap_chk(input logic to_ls, input int exp);
        int n;
        wait_lvl(!to_ls, 1'b1);
        wait_lvl(!to_ls, 1'b0);
        n = 0;
        while (lvl(to_ls) !== 1'b1 && n < 1000) begin
            n++;
            @(negedge pclk);
        end
        chk(n, exp);
    endtask : gap_chk
    // ==========================================
    // scenarios
    task t_reset;
        chk({24'h0, gates}, 32'h0);
        rd_chk(`FPO_ADDR_CTRL, 32'h0000_0300);
        rd_chk(`FPO_ADDR_PERIOD, {16'h0, `FPO_PERIOD_RST});
        rd_chk(`FPO_ADDR_DT_HS, {24'h0, `FPO_DT_RST});
        rd_chk(`FPO_ADDR_DT_LS, {24'h0, `FPO_DT_RST});
        rd_chk(`FPO_ADDR_FLAGS, `FPO_FLAGS_RST);
        rd_chk(`FPO_ADDR_MASK, `FPO_MASK_RST);
        xfer(1'b0, 12'h030, 32'h0);
        chk({31'h0, er}, 32'h1);
    endtask : t_reset
    task t_flags;
        for (int i = 0; i < 20; i++) begin
            @(posedge pclk);
            flag_src <= 20'(1 << i);
            @(posedge pclk);
            flag_src <= '0;
            repeat (2) @(posedge pclk);
            rd_chk(`FPO_ADDR_FLAGS, 32'h1 << SRC_BIT[i]);
            xfer(1'b1, `FPO_ADDR_FLAGS, 32'h0);
        end
        xfer(1'b1, `FPO_ADDR_FLAGS, 32'hffff_ffff);
        rd_chk(`FPO_ADDR_FLAGS, ~`FPO_FLAGS_RSVD);
        xfer(1'b1, `FPO_ADDR_FLAGS, 32'h1);
        rd_chk(`FPO_ADDR_FLAGS, 32'h1);
    endtask : t_flags
    task t_ref;
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, `FPO_ADDR_FLAGS, 32'h0);
            ref_sw_pins[i] <= 1'b1;
            repeat (8) @(posedge pclk);
            rd_chk(`FPO_ADDR_FLAGS, 32'h1 << (20 + i));
        end
        xfer(1'b1, `FPO_ADDR_FLAGS, 32'h0);
        ref_sw_pins <= 3'h0;
        repeat (8) @(posedge pclk);
        rd_chk(`FPO_ADDR_FLAGS, 32'h0);
    endtask : t_ref
    task t_status;
        xfer(1'b1, `FPO_ADDR_MASK, 32'h1 << 26);
        flag_src.adc_cur_clip <= 1'b1;
        @(posedge pclk);
        flag_src.adc_cur_clip <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({31'h0, status_out}, 32'h1);
        xfer(1'b1, `FPO_ADDR_MASK, 32'h1 << 27);
        repeat (3) @(posedge pclk);
        chk({31'h0, status_out}, 32'h0);
        xfer(1'b1, `FPO_ADDR_FLAGS, 32'h0);
        clk_en <= 1'b0;
        flag_src.adc_cur_clip <= 1'b1;
        @(posedge pclk);
        clk_en <= 1'b1;
        flag_src.adc_cur_clip <= 1'b0;
        rd_chk(`FPO_ADDR_FLAGS, 32'h0);
    endtask : t_status
    task t_interim;
        xfer(1'b1, `FPO_ADDR_DUTY_UV, 32'h8001_7ffe);
        xfer(1'b1, `FPO_ADDR_DUTY_WY, 32'h1234_fedc);
        xfer(1'b1, `FPO_ADDR_INT_SEL, {24'h0, `FPO_INT_SEL_UV});
        rd_chk(`FPO_ADDR_INT_DATA, 32'h8001_7ffe);
        xfer(1'b1, `FPO_ADDR_INT_SEL, {24'h0, `FPO_INT_SEL_WY});
        rd_chk(`FPO_ADDR_INT_DATA, 32'h1234_fedc);
        xfer(1'b1, `FPO_ADDR_INT_SEL, 32'h10);
        rd_chk(`FPO_ADDR_INT_DATA, 32'h0);
        xfer(1'b1, `FPO_ADDR_CTRL, 32'h310);
        rd_chk(`FPO_ADDR_CTRL, 32'h310);
    endtask : t_interim
    task t_pwm;
        int n;
        xfer(1'b1, `FPO_ADDR_PERIOD, 32'd99);
        xfer(1'b1, `FPO_ADDR_DT_HS, 32'd3);
        xfer(1'b1, `FPO_ADDR_DT_LS, 32'd5);
        xfer(1'b1, `FPO_ADDR_DUTY_UV, 32'h0);
        xfer(1'b1, `FPO_ADDR_CTRL, 32'h307);
        gap_chk(1'b1, 5);
        gap_chk(1'b0, 3);
        wait_lvl(1'b0, 1'b0);
        wait_lvl(1'b0, 1'b1);
        n = 0;
        while (gates.hs[0] === 1'b1 && n < 1000) begin
            n++;
            @(negedge pclk);
        end
        while (gates.hs[0] !== 1'b1 && n < 1000) begin
            n++;
            @(negedge pclk);
        end
        chk(n, 2 * 99);
        xfer(1'b1, `FPO_ADDR_DT_LS, 32'd0);
        repeat (400) @(posedge pclk);
        gap_chk(1'b1, 0);
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, `FPO_ADDR_DUTY_UV, i ? 32'h7fff : 32'h8000);
            repeat (450) @(posedge pclk);
            xfer(1'b1, `FPO_ADDR_FLAGS, 32'h0);
            repeat (450) @(posedge pclk);
            xfer(1'b0, `FPO_ADDR_FLAGS, 32'h0);
            chk(rd & 32'h0300_0000, 32'h0100_0000 << i);
        end
        for (int m = 1; m < 4; m++) begin
            xfer(1'b1, `FPO_ADDR_CTRL, 32'h300 | m);
            repeat (450) @(posedge pclk);
            chk({30'h0, |gates.hs, |gates.ls}, m - 1);
        end
        xfer(1'b1, `FPO_ADDR_DUTY_UV, 32'h9000_7000);
        xfer(1'b1, `FPO_ADDR_DUTY_WY, 32'h0000_9000);
        xfer(1'b1, `FPO_ADDR_CTRL, 32'h317);
        xfer(1'b1, `FPO_ADDR_FLAGS, 32'h0);
        xfer(1'b0, `FPO_ADDR_FLAGS, 32'h0);
        chk(rd & 32'h0300_0000, 32'h0300_0000);
        xfer(1'b1, `FPO_ADDR_DUTY_UV, 32'h4000);
        xfer(1'b1, `FPO_ADDR_CTRL, 32'h107);
        wait_lvl(1'b1, 1'b0);
        wait_lvl(1'b1, 1'b1);
        n = 0;
        while (gates.ls[0] === 1'b1 && n < 1000) begin
            n++;
            @(negedge pclk);
        end
        chk(n, 49);
    endtask : t_pwm
    // ==========================================
    // main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_flags();
        t_ref();
        t_status();
        t_interim();
        t_pwm();
        chk({31'h0, shoot_ff}, 32'h0);
        final_report();
    end
endmodule : fpo_top_tb
